// file: sync_regs_cfg.svh
`ifndef SYNC_REGS_CFG_SVH
`define SYNC_REGS_CFG_SVH

// register indices; byte address is four times the index
`define VSW_HI_IDX        8'h32
`define VSW_LO_IDX        8'h33
`define DLY_HI_IDX        8'h34
`define DLY_LO_IDX        8'h35
`define FAST_RX_IDX       8'h36
`define LOWPOWER_RX_IDX   8'h37
`define TERMINATION_IDX   8'h38
`define SYNC_CONFIG_IDX   8'h39
`define HSYNC_WIDTH_IDX   8'h3c
`define SYNC_STATUS_IDX   8'h3d

// reset values
`define VSW_HI_RESET      2'h0
`define VSW_LO_RESET      8'h04
`define DLY_HI_RESET      2'h0
`define DLY_LO_RESET      8'h20
`define LANE_CTRL_RESET   6'h00
`define SYNC_SRC_RESET    1'b0
`define HSYNC_WIDTH_RESET 10'h020

// field positions
`define HI_FIELD_MSB      1
`define OVERRIDE_BIT      6
`define CLOCK_LANE_BIT    4
`define LANE_FIELD_MSB    4

// timing
`define SYNC_DELAY_MAX    10'h2fe
`define BYPASS_DELAY_LIM  10'h002

`endif

// file: sync_regs_pkg.sv
package sync_regs_pkg;
	typedef logic [9:0] width10_t;
	typedef logic [4:0] lane_vec_t;
	typedef enum logic {
		SRC_EVENTS = 1'b0,
		SRC_PULSES = 1'b1
	} sync_src_t;
endpackage

// file: sync_delay_mem.sv
`timescale 1ns/1ps
`default_nettype none

// circular buffer of sync bits, read data registered
module sync_delay_mem #(
	parameter int WIDTH      = 2,
	parameter int ADDR_BITS  = 10
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic [ADDR_BITS-1:0] waddr,
	input  wire logic [WIDTH-1:0]     wdata,
	input  wire logic [ADDR_BITS-1:0] raddr,
	output logic      [WIDTH-1:0]     rdata
);
	logic [WIDTH-1:0] mem [0:(1<<ADDR_BITS)-1];

	always_ff @(posedge pclk) begin
		mem[waddr] <= wdata;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule // sync_delay_mem

`default_nettype wire

// file: sync_regs.sv
// How it works
// - vsync width is hi[1:0] over lo[7:0]
// - event mode: vsync lasts programmed hsync count
// - vsync width resets to four lines
// - sync output delayed by programmed pixel clocks; delay zero gives one
// - sync delay sets delay line fill depth
// - delay is hi[1:0] over lo; lo resets 0x20
// - fast receiver override bit six forces lanes
// - low-power override bit six forces lanes
// - low-power bit four clock, bits 3:0 data
// - termination override bit six forces lanes
// - termination bit four clock, bits 3:0 data
// - event mode: hsync width in pixel clocks
`timescale 1ns/1ps
`default_nettype none
`include "sync_regs_cfg.svh"

module sync_regs #(
	parameter int ADDR_BITS  = 10,
	parameter int DELAY_BITS = 10
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [ADDR_BITS-1:0] paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 hsync_event,
	input  wire logic                 vsync_event,
	input  wire logic                 hsync_in,
	input  wire logic                 vsync_in,
	input  wire logic [4:0]           fast_rx_auto,
	input  wire logic [4:0]           lowpower_rx_auto,
	input  wire logic [4:0]           termination_auto,
	output logic                      hsync_out,
	output logic                      vsync_out,
	output logic      [4:0]           fast_rx_lane_on,
	output logic      [4:0]           lowpower_rx_lane_on,
	output logic      [4:0]           termination_lane_on
);
	// register storage; reserved bits are not stored
	logic [1:0]                  vsw_hi_r;
	logic [7:0]                  vsw_lo_r;
	logic [1:0]                  dly_hi_r;
	logic [7:0]                  dly_lo_r;
	logic [5:0]                  lane_ctrl_r [3];
	sync_regs_pkg::sync_src_t    sync_src_r;
	sync_regs_pkg::width10_t     hsw_r;
	logic [31:0]                 prdata_r;

	// sync generation and delay state
	logic                        hs_gen_r;
	logic                        vs_gen_r;
	sync_regs_pkg::width10_t     hs_cnt_r;
	sync_regs_pkg::width10_t     line_cnt_r;
	logic [DELAY_BITS-1:0]       wptr_r;
	logic [DELAY_BITS-1:0]       fill_cnt_r;
	logic [1:0]                  bypass_r;
	logic [1:0]                  mem_q;
	logic                        primed;
	sync_regs_pkg::lane_vec_t    lane_on_r [3];

	// bus decode
	wire [7:0]  idx       = paddr[9:2];
	wire        aligned   = (paddr[1:0] == 2'b00);
	wire        hit_vsw_hi = aligned && idx == `VSW_HI_IDX;
	wire        hit_vsw_lo = aligned && idx == `VSW_LO_IDX;
	wire        hit_dly_hi = aligned && idx == `DLY_HI_IDX;
	wire        hit_dly_lo = aligned && idx == `DLY_LO_IDX;
	wire        hit_fast   = aligned && idx == `FAST_RX_IDX;
	wire        hit_lp     = aligned && idx == `LOWPOWER_RX_IDX;
	wire        hit_term   = aligned && idx == `TERMINATION_IDX;
	wire        hit_cfg    = aligned && idx == `SYNC_CONFIG_IDX;
	wire        hit_hsw    = aligned && idx == `HSYNC_WIDTH_IDX;
	wire        hit_stat   = aligned && idx == `SYNC_STATUS_IDX;
	wire        hit_any    = hit_vsw_hi | hit_vsw_lo | hit_dly_hi |
	                         hit_dly_lo | hit_fast | hit_lp | hit_term |
	                         hit_cfg | hit_hsw | hit_stat;
	wire        access     = psel && penable;
	wire        wr_ok      = access && pwrite && hit_any;
	wire [2:0]  hit_lane   = {hit_term, hit_lp, hit_fast};

	// assembled fields
	wire sync_regs_pkg::width10_t vsync_width = {vsw_hi_r, vsw_lo_r};
	wire sync_regs_pkg::width10_t sync_delay  = {dly_hi_r, dly_lo_r};

	// read data; reserved bits read zero
	wire [31:0] rd_word =
		({32{hit_vsw_hi}} & {30'h0, vsw_hi_r}) |
		({32{hit_vsw_lo}} & {24'h0, vsw_lo_r}) |
		({32{hit_dly_hi}} & {30'h0, dly_hi_r}) |
		({32{hit_dly_lo}} & {24'h0, dly_lo_r}) |
		({32{hit_fast}}   & {25'h0, lane_ctrl_r[0][5], 1'b0,
		                     lane_ctrl_r[0][4:0]}) |
		({32{hit_lp}}     & {25'h0, lane_ctrl_r[1][5], 1'b0,
		                     lane_ctrl_r[1][4:0]}) |
		({32{hit_term}}   & {25'h0, lane_ctrl_r[2][5], 1'b0,
		                     lane_ctrl_r[2][4:0]}) |
		({32{hit_cfg}}    & {31'h0, sync_src_r}) |
		({32{hit_hsw}}    & {22'h0, hsw_r}) |
		({32{hit_stat}}   & {28'h0, primed, vs_gen_r, hs_gen_r,
		                     sync_src_r});

	assign pready  = 1'b1;
	assign pslverr = access && !hit_any;
	assign prdata  = prdata_r;

	// read data captured in the setup cycle, answered with no wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0;
		end else if (psel && !penable) begin
			prdata_r <= pwrite ? 32'h0 : rd_word;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vsw_hi_r   <= `VSW_HI_RESET;
			vsw_lo_r   <= `VSW_LO_RESET;
			dly_hi_r   <= `DLY_HI_RESET;
			dly_lo_r   <= `DLY_LO_RESET;
			sync_src_r <= sync_regs_pkg::SRC_EVENTS;
			hsw_r      <= `HSYNC_WIDTH_RESET;
		end else if (wr_ok) begin
			if (hit_vsw_hi)
				vsw_hi_r <= pwdata[`HI_FIELD_MSB:0];
			if (hit_vsw_lo)
				vsw_lo_r <= pwdata[7:0];
			if (hit_dly_hi)
				dly_hi_r <= pwdata[`HI_FIELD_MSB:0];
			if (hit_dly_lo)
				dly_lo_r <= pwdata[7:0];
			if (hit_cfg)
				sync_src_r <= sync_regs_pkg::sync_src_t'(pwdata[0]);
			if (hit_hsw)
				hsw_r <= pwdata[9:0];
		end
	end

	// per-group lane control and lane enable outputs
	wire sync_regs_pkg::lane_vec_t lane_auto [3];
	assign lane_auto[0] = fast_rx_auto;
	assign lane_auto[1] = lowpower_rx_auto;
	assign lane_auto[2] = termination_auto;

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_lane
			wire override = lane_ctrl_r[g][5];
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					lane_ctrl_r[g] <= `LANE_CTRL_RESET;
				end else if (wr_ok && hit_lane[g]) begin
					lane_ctrl_r[g] <= {pwdata[`OVERRIDE_BIT],
					                   pwdata[`LANE_FIELD_MSB:0]};
				end
			end
			// bit 4 clock lane, bits 3:0 data lanes 3..0
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					lane_on_r[g] <= 5'h00;
				end else begin
					lane_on_r[g] <= override ? lane_ctrl_r[g][4:0]
					                         : lane_auto[g];
				end
			end
		end
	endgenerate

	assign fast_rx_lane_on     = lane_on_r[0];
	assign lowpower_rx_lane_on = lane_on_r[1];
	assign termination_lane_on = lane_on_r[2];

	// sync pulse generation from sync events
	wire        gen_mode = (sync_src_r == sync_regs_pkg::SRC_EVENTS);
	wire        hs_start = gen_mode && hsync_event;
	wire        vs_start = gen_mode && vsync_event;
	wire [10:0] hs_next  = {1'b0, hs_cnt_r} + 11'h001;
	wire [10:0] ln_next  = {1'b0, line_cnt_r} + 11'h001;
	wire        hs_done  = hs_next >= {1'b0, hsw_r};
	wire        vs_done  = ln_next >= {1'b0, vsync_width};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hs_gen_r <= 1'b0;
			hs_cnt_r <= 10'h000;
		end else if (hs_start) begin
			hs_gen_r <= 1'b1;
			hs_cnt_r <= 10'h000;
		end else if (hs_gen_r) begin
			if (hs_done || !gen_mode)
				hs_gen_r <= 1'b0;
			else
				hs_cnt_r <= hs_next[9:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vs_gen_r   <= 1'b0;
			line_cnt_r <= 10'h000;
		end else if (vs_start) begin
			vs_gen_r   <= 1'b1;
			line_cnt_r <= 10'h000;
		end else if (vs_gen_r && !gen_mode) begin
			vs_gen_r <= 1'b0;
		end else if (vs_gen_r && hs_start) begin
			if (vs_done)
				vs_gen_r <= 1'b0;
			else
				line_cnt_r <= ln_next[9:0];
		end
	end

	wire [1:0] sync_src = gen_mode ? {vs_gen_r, hs_gen_r}
	                               : {vsync_in, hsync_in};

	// delay line; fill depth follows the programmed delay
	wire [DELAY_BITS-1:0] dly_w = sync_delay[DELAY_BITS-1:0];
	wire [DELAY_BITS-1:0] raddr = wptr_r - dly_w + DELAY_BITS'(1);
	assign                primed = fill_cnt_r >= dly_w;
	wire                  use_bypass = sync_delay < `BYPASS_DELAY_LIM;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr_r     <= '0;
			fill_cnt_r <= '0;
			bypass_r   <= 2'b00;
		end else begin
			wptr_r   <= wptr_r + DELAY_BITS'(1);
			bypass_r <= sync_src;
			if (fill_cnt_r != '1)
				fill_cnt_r <= fill_cnt_r + DELAY_BITS'(1);
		end
	end

	sync_delay_mem #(
		.WIDTH     (2),
		.ADDR_BITS (DELAY_BITS)
	) u_delay (
		.pclk    (pclk),
		.presetn (presetn),
		.waddr   (wptr_r),
		.wdata   (sync_src),
		.raddr   (raddr),
		.rdata   (mem_q)
	);

	// delays below two use the single-stage path
	wire [1:0] sync_dly = use_bypass ? bypass_r
	                                 : (primed ? mem_q : 2'b00);
	assign hsync_out = sync_dly[0];
	assign vsync_out = sync_dly[1];

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_vsw_write: assert property (
		wr_ok && hit_vsw_hi |=> vsync_width[9:8] == $past(pwdata[1:0]))
		else $error("vsync width high bits not taken");
	chk_vsw_reset: assert property (
		$rose(presetn) |-> vsync_width == 10'h004)
		else $error("vsync width reset value wrong");
	chk_dly_reset: assert property (
		$rose(presetn) |-> sync_delay == 10'h020)
		else $error("sync delay reset value wrong");
	chk_vs_end: assert property (
		$fell(vs_gen_r) && $past(gen_mode) |->
		$past(hs_start) && $past(ln_next) >= {1'b0, $past(vsync_width)})
		else $error("vsync ended off a line boundary");
	chk_hs_width: assert property (
		$fell(hs_gen_r) && $past(gen_mode) |->
		$past(hs_next) >= {1'b0, $past(hsw_r)})
		else $error("hsync pulse ended early");
	chk_delay_two: assert property (
		sync_delay == 10'h002 && $past(sync_delay) == 10'h002 &&
		$past(sync_delay, 2) == 10'h002 && primed |->
		hsync_out == $past(sync_src[0], 2))
		else $error("sync delay of two not kept");
	chk_fast_ovr: assert property (
		lane_ctrl_r[0][5] |=> fast_rx_lane_on == $past(lane_ctrl_r[0][4:0]))
		else $error("fast receiver override ignored");
	chk_lp_ovr: assert property (
		lane_ctrl_r[1][5] |=>
		lowpower_rx_lane_on == $past(lane_ctrl_r[1][4:0]))
		else $error("low-power override ignored");
	chk_term_ovr: assert property (
		lane_ctrl_r[2][5] |=>
		termination_lane_on == $past(lane_ctrl_r[2][4:0]))
		else $error("termination override ignored");
	chk_auto_lanes: assert property (
		!lane_ctrl_r[0][5] |=> fast_rx_lane_on == $past(fast_rx_auto))
		else $error("automatic lane control not followed");
	chk_resv_zero: assert property (
		psel && !penable && !pwrite && hit_vsw_hi |=> prdata[31:2] == 30'h0)
		else $error("reserved bits read nonzero");
endmodule // sync_regs

`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sync_regs_cfg.svh"

module testbench;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [9:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        hsync_event;
	logic        vsync_event;
	logic        hsync_in;
	logic        vsync_in;
	logic        hsync_out;
	logic        vsync_out;
	logic [14:0] auto_all;
	logic [14:0] lanes_all;
	logic [31:0] rd;
	logic        er;
	int          n_fail;
	int          n_tests;
	int          hs_cnt;
	int          vs_cnt;
	int          k;

	sync_regs u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .hsync_event(hsync_event),
		.vsync_event(vsync_event), .hsync_in(hsync_in), .vsync_in(vsync_in),
		.fast_rx_auto(auto_all[4:0]), .lowpower_rx_auto(auto_all[9:5]),
		.termination_auto(auto_all[14:10]), .hsync_out(hsync_out),
		.vsync_out(vsync_out), .fast_rx_lane_on(lanes_all[4:0]),
		.lowpower_rx_lane_on(lanes_all[9:5]),
		.termination_lane_on(lanes_all[14:10])
	);

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	always @(negedge pclk) begin
		if (hsync_out === 1'b1)
			hs_cnt++;
		if (vsync_out === 1'b1)
			vs_cnt++;
	end

	task wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one setup cycle, then access until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] idx,
		input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		if (n >= 50)
			n_fail++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rchk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		check(nm, rd, exp);
	endtask

	task idle(input int n);
		repeat (n) @(posedge pclk);
	endtask

	logic [7:0]  ridx [9] = '{`VSW_HI_IDX, `VSW_LO_IDX, `DLY_HI_IDX,
		`DLY_LO_IDX, `FAST_RX_IDX, `LOWPOWER_RX_IDX, `TERMINATION_IDX,
		`SYNC_CONFIG_IDX, `HSYNC_WIDTH_IDX};
	logic [31:0] rexp [9] = '{32'h0, 32'h4, 32'h0, 32'h20, 32'h0,
		32'h0, 32'h0, 32'h0, 32'h20};
	logic [9:0]  dly  [4] = '{10'h005, 10'h105, 10'h002, 10'h000};
	logic [9:0]  hsw  [4] = '{10'h003, 10'h101, 10'h001, 10'h002};

	initial begin
		{presetn, psel, penable, pwrite, hsync_event, vsync_event} = '0;
		{hsync_in, vsync_in, paddr, pwdata, hs_cnt, vs_cnt} = '0;
		{n_fail, n_tests} = '0;
		auto_all = 15'h5a93;
		idle(2);
		presetn <= 1'b1;
		for (int i = 0; i < 9; i++)
			rchk("reset_value", ridx[i], rexp[i]);
		apb(1'b1, `VSW_HI_IDX, 32'hffffffff);
		rchk("vsw_hi", `VSW_HI_IDX, 32'h3);
		apb(1'b1, `DLY_HI_IDX, 32'hfffffffe);
		rchk("dly_hi", `DLY_HI_IDX, 32'h2);
		apb(1'b0, 8'h3b, 32'h0);
		check("unmapped_err", er, 32'h1);
		check("unmapped_data", rd, 32'h0);
		$display("test registers done");
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, `FAST_RX_IDX + i, 32'h0a);
			idle(2);
			check("lanes_auto", lanes_all[i*5+:5], auto_all[i*5+:5]);
			apb(1'b1, `FAST_RX_IDX + i, 32'hff);
			rchk("lane_reg", `FAST_RX_IDX + i, 32'h5f);
			idle(2);
			check("lanes_all_on", lanes_all[i*5+:5], 32'h1f);
			apb(1'b1, `FAST_RX_IDX + i, 32'h4a);
			idle(2);
			check("lanes_forced", lanes_all[i*5+:5], 32'h0a);
			apb(1'b1, `FAST_RX_IDX + i, 32'h0);
		end
		$display("test lanes done");
		// sync delay and hsync width, delay line flushed before each pulse
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `DLY_HI_IDX, {30'h0, dly[i][9:8]});
			apb(1'b1, `DLY_LO_IDX, {24'h0, dly[i][7:0]});
			apb(1'b1, `HSYNC_WIDTH_IDX, {22'h0, hsw[i]});
			idle(300);
			hs_cnt = 0;
			@(posedge pclk);
			hsync_event <= 1'b1;
			@(posedge pclk);
			hsync_event <= 1'b0;
			k = 0;
			@(negedge pclk);
			while (hsync_out !== 1'b1 && k < 900) begin
				k++;
				@(negedge pclk);
			end
			check("sync_latency", k, dly[i] < 2 ? 1 : dly[i]);
			idle(300);
			check("hsync_width", hs_cnt, hsw[i]);
		end
		$display("test delay done");
		apb(1'b1, `SYNC_CONFIG_IDX, 32'h1);
		{hs_cnt, vs_cnt} = '0;
		@(posedge pclk);
		hsync_event <= 1'b1;
		vsync_event <= 1'b1;
		@(posedge pclk);
		{hsync_event, vsync_event} <= 2'b00;
		hsync_in <= 1'b1;
		idle(4);
		hsync_in <= 1'b0;
		idle(10);
		check("pulse_mode_h", hs_cnt, 32'd4);
		check("pulse_mode_v", vs_cnt, 32'd0);
		apb(1'b1, `SYNC_CONFIG_IDX, 32'h0);
		$display("test pulse mode done");
		apb(1'b1, `VSW_HI_IDX, 32'h1);
		apb(1'b1, `VSW_LO_IDX, 32'h1);
		apb(1'b1, `HSYNC_WIDTH_IDX, 32'h1);
		idle(10);
		{hs_cnt, vs_cnt} = '0;
		@(posedge pclk);
		vsync_event <= 1'b1;
		@(posedge pclk);
		vsync_event <= 1'b0;
		repeat (257) begin
			@(posedge pclk);
			hsync_event <= 1'b1;
			@(posedge pclk);
			hsync_event <= 1'b0;
		end
		idle(20);
		check("vsync_lines", vs_cnt, 32'd514);
		check("hsync_count", hs_cnt, 32'd257);
		rchk("status", `SYNC_STATUS_IDX, 32'h8);
		$display("test vsync done");
		wrap_up();
	end

	initial begin
		#200us;
		n_fail++;
		wrap_up();
	end
endmodule // testbench

`default_nettype wire
